// ==== hw/ivas_defines.vh ====
// Constants for the interrupt vector address select block
//--------------------------------------------------------------
//--------------------------------------------------------------
`ifndef IVAS_DEFINES_VH
`define IVAS_DEFINES_VH

`define IVAS_ADDR_W        24
`define IVAS_VEC_W         7
`define IVAS_NUM_TRAPS     8
`define IVAS_NUM_IRQS      118
`define IVAS_NUM_VECS      126
`define IVAS_PRIMARY_BASE  24'h000004
`define IVAS_ALT_OFFSET    24'h000100
`define IVAS_CODE_START    24'h000200
`define IVAS_RESET_PC      24'h000000
`define IVAS_IRQ_VEC_OFS   7'h08
`define IVAS_TRAP_RSVD0    7'h00
`define IVAS_TRAP_OSC      7'h01
`define IVAS_TRAP_ADDR     7'h02
`define IVAS_TRAP_STACK    7'h03
`define IVAS_TRAP_MATH     7'h04

`endif

// ==== hw/ivas_prio.v ====
// Natural-order picker: lowest pending vector number wins
`timescale 1ns/100ps
module ivas_prio #(
	parameter NVEC = 126,
	parameter VW   = 7
) (
	input  wire            mclk,   // System clock
	input  wire            rst,    // Synchronous reset
	input  wire [NVEC-1:0] pend,   // Pending vectors, bit n is vector n
	output reg             found,  // Some vector pending
	output reg  [VW-1:0]   vec     // Lowest pending vector number
);
	reg          next_found;
	reg [VW-1:0] next_vec;
	integer      i;

	// Scan downward so the lowest index is assigned last
	always @* begin
		next_found = 1'b0;
		next_vec   = {VW{1'b0}};
		for (i = NVEC - 1; i >= 0; i = i - 1) begin
			if (pend[i]) begin
				next_found = 1'b1;
				next_vec   = i[VW-1:0];
			end
		end
	end

	always @(posedge mclk) begin
		if (rst) begin
			found <= 1'b0;
			vec   <= {VW{1'b0}};
		end else begin
			found <= next_found;
			vec   <= next_vec;
		end
	end
endmodule

// ==== hw/ivas_top.v ====
// Vector fetch address generation and handler load for the CPU core
`timescale 1ns/100ps
`include "ivas_defines.vh"
module ivas_top #(
	parameter AW = `IVAS_ADDR_W,
	parameter VW = `IVAS_VEC_W
) (
	input  wire                     mclk,             // System clock, 200 MHz
	input  wire                     rst,              // Synchronous reset, active high
	input  wire                     alt_table_select, // Use alternate vector table
	input  wire [`IVAS_NUM_TRAPS-1:0] trap_req,       // Trap requests, bit n is trap slot n
	input  wire [`IVAS_NUM_IRQS-1:0]  irq_req,        // Interrupt requests by request number
	input  wire                     core_accept,      // Core can take a vector now
	input  wire [AW-1:0]            pmem_rdata,       // Program memory read data
	input  wire                     pmem_rvalid,      // Read data valid
	output reg                      pmem_rd,          // Vector read strobe, one cycle
	output reg  [AW-1:0]            pmem_addr,        // Vector slot address
	output reg                      pc_load,          // Load program counter
	output reg  [AW-1:0]            pc_value,         // New program counter value
	output reg  [VW-1:0]            vec_taken,        // Vector number being serviced
	output reg                      alt_used,         // Fetch used the alternate table
	output reg                      busy              // Vector fetch in progress
);
	//--------------------------------------------------------------
	// Address arithmetic
	//--------------------------------------------------------------
	function [AW-1:0] slot_addr;
		input          alt;
		input [VW-1:0] vnum;
		reg   [AW-1:0] base;
		begin
			base = alt ? (`IVAS_PRIMARY_BASE + `IVAS_ALT_OFFSET)
				: `IVAS_PRIMARY_BASE;
			slot_addr = base + {{(AW-VW-1){1'b0}}, vnum, 1'b0};
		end
	endfunction

	//--------------------------------------------------------------
	// Pending vectors: traps occupy 0..7, requests follow from 8
	//--------------------------------------------------------------
	wire [`IVAS_NUM_VECS-1:0] pend;
	wire                      found;
	wire [VW-1:0]             vec;
	assign pend = {irq_req, trap_req};

	ivas_prio #(
		.NVEC (`IVAS_NUM_VECS),
		.VW   (VW)
	) u_prio (
		.mclk  (mclk),
		.rst   (rst),
		.pend  (pend),
		.found (found),
		.vec   (vec)
	);

	//--------------------------------------------------------------
	// Fetch sequencer
	//--------------------------------------------------------------
	localparam ST_IDLE = 2'b00;
	localparam ST_WAIT = 2'b01;
	localparam ST_DONE = 2'b10;

	reg [1:0] state;

	// Table choice is frozen at the read so a toggle mid-fetch cannot split it
	always @(posedge mclk) begin
		if (rst) begin
			// Reset bypasses the controller: PC forced to zero, no read issued
			state     <= ST_IDLE;
			pmem_rd   <= 1'b0;
			pmem_addr <= {AW{1'b0}};
			pc_load   <= 1'b1;
			pc_value  <= `IVAS_RESET_PC;
			vec_taken <= {VW{1'b0}};
			alt_used  <= 1'b0;
			busy      <= 1'b0;
		end else begin
			pmem_rd <= 1'b0;
			pc_load <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (core_accept && found) begin
						pmem_rd   <= 1'b1;
						pmem_addr <= slot_addr(alt_table_select, vec);
						vec_taken <= vec;
						alt_used  <= alt_table_select;
						busy      <= 1'b1;
						state     <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (pmem_rvalid) begin
						pc_load  <= 1'b1;
						pc_value <= pmem_rdata;
						busy     <= 1'b0;
						state    <= ST_DONE;
					end
				end
				ST_DONE: begin
					// Wait for the core to drop accept; stale picks are ignored
					if (!core_accept) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end
endmodule

// ==== test/ivas_pmem.sv ====
// Program memory model answering vector slot reads
`timescale 1ns/100ps
module ivas_pmem (
	input  wire        mclk,       // Clock
	input  wire        pmem_rd,    // Slot read
	input  wire [23:0] pmem_addr,  // Slot address
	output reg  [23:0] pmem_rdata, // Handler address
	output reg         pmem_rvalid // Data valid
);
	initial pmem_rvalid = 1'b0;
	initial pmem_rdata = 24'h000000;
	// Content tells slots apart; bus toggles when idle
	// Reset jump words and table filling are software's; never fetched here
	always @(posedge mclk) begin
		pmem_rvalid <= pmem_rd;
		pmem_rdata <= pmem_rd ? {8'h00, pmem_addr[15:0]} ^ 24'h3C0000 : ~pmem_rdata;
	end
endmodule

// ==== test/ivas_top_sva.sv ====
// Checker of vector fetch addresses and reset behaviour
`timescale 1ns/100ps
module ivas_chk (
	input wire        mclk,             // Clock
	input wire        rst,              // Reset
	input wire        alt_table_select, // Select
	input wire [7:0]  trap_req,         // Traps
	input wire [23:0] pmem_rdata,       // Data
	input wire        pmem_rvalid,      // Valid
	input wire        pmem_rd,          // Read
	input wire [23:0] pmem_addr,        // Address
	input wire        pc_load,          // Load
	input wire [23:0] pc_value,         // New PC
	input wire [6:0]  vec_taken,        // Vector
	input wire        alt_used,         // Table
	input wire        busy              // Busy
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	a_fetch_addr: assert property (pmem_rd |->
		pmem_addr == (alt_used ? 24'h000104 : 24'h000004) + {vec_taken, 1'b0})
		else $error("bad slot address");
	a_code_bound: assert property (pmem_rd |-> pmem_addr < 24'h000200)
		else $error("slot in code space");
	a_pc_slot: assert property (pmem_rvalid && busy |=>
		pc_load && pc_value == $past(pmem_rdata))
		else $error("pc not from slot");
	a_reset_pc: assert property (disable iff (1'b0) rst |=>
		pc_load && pc_value == 24'h0 && !pmem_rd)
		else $error("reset not to zero");
	a_load_once: assert property (pc_load |=> !pc_load)
		else $error("load too long");
	a_fetch_ends: assert property (pmem_rd |-> ##[2:20] pc_load)
		else $error("fetch hangs");
	a_trap_first: assert property ((trap_req != 8'h00)[*3] ##0 pmem_rd |->
		vec_taken < 7'h08)
		else $error("irq beat trap");
	a_table_hold: assert property ($stable(alt_table_select)[*2] ##0 pmem_rd |->
		alt_used == alt_table_select) else $error("wrong table");
	cover property (pmem_rd && alt_used);
	cover property (pmem_rd && vec_taken == 7'h7D);
	cover property (pmem_rd && vec_taken < 7'h08);
endmodule
bind ivas_top ivas_chk chk_u (.*);

// ==== test/interrupt_vector_address_select_tb.sv ====
// Self-checking bench for the vector address select block
`timescale 1ns/100ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin n_mismatch++; \
	$display("wrong value %s exp %h got %h", n, e, s); end end
module interrupt_vector_address_select_tb;
	logic         mclk = 1'b0, rst = 1'b1, alt_table_select = 1'b0, core_accept = 1'b0;
	logic [7:0]   trap_req = 8'h00;
	logic [117:0] irq_req = '0;
	wire  [23:0]  pmem_rdata, pmem_addr, pc_value;
	wire          pmem_rvalid, pmem_rd, pc_load, alt_used, busy;
	wire  [6:0]   vec_taken;
	int           n_mismatch = 0, tests_run = 0;
	ivas_top dut_u (.*);
	ivas_pmem pmem_u (.*);
	initial forever #2.5 mclk = ~mclk;
	task automatic complete_run;
		if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic fetch(input logic [7:0] t, input logic [117:0] q, input logic a,
		input logic [6:0] v);
		logic [23:0] ea;
		ea = (a ? 24'h000104 : 24'h000004) + {v, 1'b0};
		@(negedge mclk);
		trap_req = t;
		irq_req = q;
		alt_table_select = a;
		core_accept = 1'b1;
		repeat (12) if (pc_load !== 1'b1) @(negedge mclk);
		`CHK("pc_load", 1'b1, pc_load)
		`CHK("busy", 1'b0, busy)
		`CHK("pmem_rd", 1'b0, pmem_rd)
		`CHK("pmem_addr", ea, pmem_addr)
		`CHK("vec_taken", v, vec_taken)
		`CHK("alt_used", a, alt_used)
		`CHK("pc_value", ea ^ 24'h3C0000, pc_value)
		trap_req = 8'h00;
		irq_req = '0;
		core_accept = 1'b0;
		repeat (2) @(negedge mclk);
	endtask
	task automatic t_reset;
		repeat (4) @(negedge mclk);
		`CHK("pc_load", 1'b1, pc_load)
		`CHK("pc_value", 24'h000000, pc_value)
		`CHK("pmem_rd", 1'b0, pmem_rd)
		rst = 1'b0;
	endtask
	task automatic t_irq_edges;
		fetch(8'h00, 118'h1, 1'b0, 7'h08);
		fetch(8'h00, 118'h1, 1'b1, 7'h08);
		fetch(8'h00, {1'b1, 117'h0}, 1'b1, 7'h7D);
		fetch(8'h00, {1'b1, 117'h0}, 1'b0, 7'h7D);
	endtask
	task automatic t_traps;
		for (int i = 0; i < 8; i++) fetch(8'h01 << i, '0, i[0], i[6:0]);
	endtask
	task automatic t_prio;
		fetch(8'h18, 118'h28, 1'b0, 7'h03);
		fetch(8'h00, 118'h3 << 46, 1'b1, 7'h36);
	endtask
	initial begin
		t_reset;
		t_irq_edges;
		t_traps;
		t_prio;
		complete_run;
	end
	// Fourteen fetches of about seven cycles; ample margin
	initial begin
		#3000;
		n_mismatch++;
		complete_run;
	end
endmodule
